// *** core/sar_adc_sequencer.sv ***
`timescale 1ns/100ps
`include "sar_adc_map.svh"
module sar_adc_sequencer
    import sar_adc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    input  wire logic        timer0_ovf,
    input  wire logic        timer1_ovf,
    input  wire logic [3:0]  timer_low_ovf,
    input  wire logic [3:0]  timer_high_ovf,
    input  wire logic        external_start_pin,
    input  wire logic        standby,
    input  wire logic        sar_compare,
    output logic             converter_power,
    output logic             track_enable,
    output logic             sar_clock,
    output logic [9:0]       sar_trial,
    output logic             temp_sensor_route,
    output logic             done_irq
);
    import sar_adc_pkg::*;

    logic [7:0]  control_r;
    logic [4:0]  divider_r;
    logic        left_r;
    logic [5:0]  input_sel_r;
    logic [3:0]  timer16_r;
    logic [7:0]  res_high_r;
    logic [7:0]  res_low_r;
    logic        active_r;
    logic        done_r;
    logic        active_d_r;
    logic [1:0]  pin_sync_r;
    logic        pin_prev_r;
    logic [4:0]  div_cnt_r;
    logic        sar_clk_r;
    logic [3:0]  step_r;
    logic [9:0]  code_r;
    logic [9:0]  trial_r;
    logic        track_r;
    logic        irq_r;
    logic [7:0]  rdata_r;
    logic        temp_r;
    seq_state_e  state_r;
    seq_state_e  state_nxt;

    // Decoded fields
    wire         conv_on    = control_r[`CTL_ON];
    wire         lp_track   = control_r[`CTL_TRACK_LP];
    wire         eight_bit  = control_r[`CTL_EIGHT_BIT];
    wire [2:0]   src_sel    = control_r[`CTL_SRC_HI:`CTL_SRC_LO];
    wire         wr_ctl     = wr && addr == `ADDR_CONTROL;
    wire         wr_cfg     = wr && addr == `ADDR_CONFIG;
    wire         wr_isel    = wr && addr == `ADDR_INPUT_SEL;
    wire         wr_tmode   = wr && addr == `ADDR_TIMER_MODE;
    wire         sw_start   = wr_ctl && wdata[`CTL_ACTIVE];
    wire         pin_now    = pin_sync_r[1];
    wire         pin_rise   = pin_now && !pin_prev_r;

    // Timer 2..5 overflow picks byte by timer width
    wire [3:0]   tmr_ovf = (timer16_r & timer_high_ovf) |
                           (~timer16_r & timer_low_ovf);

    // Trigger selection in listed order
    logic        trig;
    always_comb begin
        unique case (start_source_e'(src_sel))
            SRC_SOFTWARE: trig = sw_start;
            SRC_TIMER0:   trig = timer0_ovf;
            SRC_TIMER2:   trig = tmr_ovf[0];
            SRC_TIMER1:   trig = timer1_ovf;
            SRC_PIN:      trig = pin_rise;
            SRC_TIMER3:   trig = tmr_ovf[1];
            SRC_TIMER4:   trig = tmr_ovf[2];
            SRC_TIMER5:   trig = tmr_ovf[3];
        endcase
    end

    // SAR tick once every divider+1 system clocks
    wire         sar_tick = div_cnt_r == divider_r;
    wire         idle     = state_r == ST_IDLE;
    wire         start    = conv_on && idle && trig;
    wire         conv_end = state_r == ST_CONVERT && sar_tick &&
                            step_r == `LAST_BIT;
    wire         pin_lp   = lp_track && src_sel == SRC_PIN;
    wire [9:0]   bit_mask = 10'h200 >> step_r;
    wire [9:0]   code_fin = sar_compare ? trial_r : (trial_r & ~bit_mask);

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:
                if (start) begin
                    // Pin mode already tracked while low
                    state_nxt = (lp_track && !pin_lp) ? ST_TRACK
                                                      : ST_CONVERT;
                end
            ST_TRACK:
                if (sar_tick && step_r == `TRACK_CLOCKS - 4'h1) begin
                    state_nxt = ST_CONVERT;
                end
            ST_CONVERT:
                if (conv_end) begin
                    state_nxt = ST_IDLE;
                end
        endcase
        if (!conv_on) begin
            state_nxt = ST_IDLE;
        end
    end

    // Result formatting
    // Eight-bit mode keeps only the top code bits; unused bits stay zero
    wire [15:0]  res_right = eight_bit ? {8'h00, code_fin[9:2]}
                                       : {6'h00, code_fin};
    wire         diff_mode = timer16_r[3] & 1'b0;
    wire [15:0]  res_sext  = {{6{code_fin[9]}}, code_fin};
    wire [15:0]  res_left  = {code_fin, 6'h00};
    wire [15:0]  res_word  = eight_bit ? res_right
                           : left_r ? res_left
                           : (diff_mode ? res_sext : res_right);

    // Register file and status
    always_ff @(posedge clk) begin
        if (reset) begin
            control_r   <= `RST_CONTROL;
            divider_r   <= `RST_DIVIDER;
            left_r      <= 1'b0;
            input_sel_r <= `RST_INPUT_SEL;
            timer16_r   <= 4'h0;
            res_high_r  <= 8'h00;
            res_low_r   <= 8'h00;
            done_r      <= 1'b0;
        end else begin
            if (wr_ctl) begin
                control_r <= wdata;
            end
            if (wr_cfg) begin
                divider_r <= wdata[`CFG_DIV_HI:`CFG_DIV_LO];
                left_r    <= wdata[`CFG_LEFT];
            end
            if (wr_isel) begin
                input_sel_r <= wdata[5:0];
            end
            if (wr_tmode) begin
                timer16_r <= wdata[3:0];
            end
            if (conv_end) begin
                res_high_r <= res_word[15:8];
                res_low_r  <= res_word[7:0];
            end
            // Set wins over a software clear in the same cycle
            if (active_d_r && !active_r) begin
                done_r <= 1'b1;
            end else if (wr_ctl && !wdata[`CTL_DONE]) begin
                done_r <= 1'b0;
            end
        end
    end

    // Sequencer, divider and pin synchroniser
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r    <= ST_IDLE;
            step_r     <= 4'h0;
            div_cnt_r  <= 5'h00;
            active_r   <= 1'b0;
            active_d_r <= 1'b0;
            pin_sync_r <= 2'b00;
            pin_prev_r <= 1'b0;
            trial_r    <= 10'h000;
        end else begin
            pin_sync_r <= {pin_sync_r[0], external_start_pin};
            pin_prev_r <= pin_now;
            active_d_r <= active_r;
            div_cnt_r  <= (idle || sar_tick) ? 5'h00 : div_cnt_r + 5'h01;
            state_r    <= state_nxt;
            // Busy from start until the last bit is decided
            active_r   <= start || (!idle && !conv_end && conv_on);
            if (state_nxt != state_r) begin
                step_r  <= 4'h0;
                trial_r <= 10'h200;
            end else if (sar_tick) begin
                step_r  <= step_r + 4'h1;
                if (state_r == ST_CONVERT) begin
                    trial_r <= code_fin | (bit_mask >> 1);
                end
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_r   <= 8'h00;
            track_r   <= 1'b0;
            sar_clk_r <= 1'b0;
            irq_r     <= 1'b0;
            temp_r    <= 1'b0;
        end else begin
            unique case (addr)
                `ADDR_CONTROL:    rdata_r <= {control_r[7:6], done_r,
                                              active_r, control_r[3:0]};
                `ADDR_CONFIG:     rdata_r <= {divider_r, left_r, 2'b00};
                `ADDR_RES_HIGH:   rdata_r <= res_high_r;
                `ADDR_RES_LOW:    rdata_r <= res_low_r;
                `ADDR_INPUT_SEL:  rdata_r <= {2'b00, input_sel_r};
                `ADDR_TIMER_MODE: rdata_r <= {4'h0, timer16_r};
                default:          rdata_r <= 8'h00;
            endcase
            // Tracking per mode; off in standby
            track_r <= conv_on && !standby && state_r != ST_CONVERT &&
                       (!lp_track || state_r == ST_TRACK ||
                        (pin_lp && !pin_now));
            sar_clk_r <= !idle && sar_tick;
            irq_r     <= active_d_r && !active_r;
            temp_r    <= input_sel_r == `TEMP_SENSOR_SEL;
        end
    end

    assign rdata             = rdata_r;
    assign converter_power   = control_r[`CTL_ON];
    assign track_enable      = track_r;
    assign sar_clock         = sar_clk_r;
    assign sar_trial         = trial_r;
    assign temp_sensor_route = temp_r;
    assign done_irq          = irq_r;

    // Active falls only with done rising next cycle
    a_done_follows: assert property (@(posedge clk) disable iff (reset)
        $fell(active_r) |=> done_r) else $error("done not set");
    a_off_idle: assert property (@(posedge clk) disable iff (reset)
        !conv_on |=> state_r == ST_IDLE) else $error("runs while off");
    a_busy_hold: assert property (@(posedge clk) disable iff (reset)
        state_r == ST_CONVERT |-> active_r) else $error("busy dropped");
    a_lp_track: assert property (@(posedge clk) disable iff (reset)
        state_r == ST_IDLE ##1 state_r == ST_TRACK |->
        state_r == ST_TRACK [*3]) else $error("short track");
    a_no_restart: assert property (@(posedge clk) disable iff (reset)
        state_r == ST_CONVERT && !conv_end && conv_on |=>
        state_r == ST_CONVERT) else $error("restarted");
    a_tick_gap: assert property (@(posedge clk) disable iff (reset)
        sar_tick && !idle |=> div_cnt_r == 5'h00) else $error("tick");
    a_se_zero: assert property (@(posedge clk) disable iff (reset)
        conv_end && !eight_bit && !left_r |=> res_high_r[7:2] == 6'h00)
        else $error("upper bits set");
    a_left_low: assert property (@(posedge clk) disable iff (reset)
        conv_end && !eight_bit && left_r |=> res_low_r[5:0] == 6'h00)
        else $error("low bits set");
endmodule

// *** common/sar_adc_map.svh ***
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH
// Register addresses
`define ADDR_CONTROL    8'h00
`define ADDR_CONFIG     8'h01
`define ADDR_RES_HIGH   8'h02
`define ADDR_RES_LOW    8'h03
`define ADDR_INPUT_SEL  8'h04
`define ADDR_TIMER_MODE 8'h05
// Control register fields
`define CTL_ON          7
`define CTL_TRACK_LP    6
`define CTL_DONE        5
`define CTL_ACTIVE      4
`define CTL_EIGHT_BIT   3
`define CTL_SRC_HI      2
`define CTL_SRC_LO      0
// Config register fields
`define CFG_DIV_HI      7
`define CFG_DIV_LO      3
`define CFG_LEFT        2
// Reset values
`define RST_CONTROL     8'h00
`define RST_DIVIDER     5'h1f
`define RST_INPUT_SEL   6'h00
// Sequencing counts in conversion clocks
`define TRACK_CLOCKS    4'h3
`define CONV_CLOCKS     4'ha
`define LAST_BIT        4'h9
// Temperature sensor mux code
`define TEMP_SENSOR_SEL 6'h1e
`endif

// *** common/sar_adc_pkg.sv ***
package sar_adc_pkg;
    typedef enum logic [2:0] {
        SRC_SOFTWARE, SRC_TIMER0, SRC_TIMER2, SRC_TIMER1,
        SRC_PIN, SRC_TIMER3, SRC_TIMER4, SRC_TIMER5
    } start_source_e;
    typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONVERT} seq_state_e;
endpackage

// *** verif/sar_comparator_model.sv ***
`timescale 1ns/100ps
// Ideal analog comparator standing in for the converter core
module sar_comparator_model (
    input  wire logic [9:0] sar_trial,
    input  wire logic [9:0] target_code,
    output logic            sar_compare
);
    // Keep the trial bit while the trial does not exceed the input
    assign sar_compare = (sar_trial <= target_code);
endmodule

// *** verif/sar_adc_sequencer_tb_top.sv ***
`timescale 1ns/100ps
`include "sar_adc_map.svh"
module sar_adc_sequencer_tb_top;
    import sar_adc_pkg::*;
    logic       clk, reset, wr, rd, pin, standby, cmp;
    logic [7:0] addr, wdata, rdata;
    logic       t0, t1, pwr, trk, sclk, temp, irq;
    logic [3:0] tlo, thi;
    logic [9:0] trial, code;
    int         num_errors, checks, irqs;

    sar_adc_sequencer dut_u (.clk(clk), .reset(reset), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .timer0_ovf(t0),
        .timer1_ovf(t1), .timer_low_ovf(tlo), .timer_high_ovf(thi),
        .external_start_pin(pin), .standby(standby), .sar_compare(cmp),
        .converter_power(pwr), .track_enable(trk), .sar_clock(sclk),
        .sar_trial(trial), .temp_sensor_route(temp), .done_irq(irq));
    sar_comparator_model cmp_u (.sar_trial(trial), .target_code(code),
        .sar_compare(cmp));

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // Count completion pulses to match against done-flag sets
    always @(posedge clk) if (irq === 1'b1) irqs++;

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) begin wr <= 1; addr <= a; wdata <= d; end
        @(posedge clk) wr <= 0;
    endtask
    task rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) begin rd <= 1; addr <= a; end
        @(posedge clk) rd <= 0;
        #1 d = rdata;
    endtask
    // Fire one source's trigger for one cycle; pin is a dedicated input
    task fire(input int s);
        @(posedge clk) begin
            t0 <= (s == 1);
            t1 <= (s == 3);
            tlo <= (s == 2) ? 4'h1 : (s > 4) ? 4'h1 << (s - 4) : 4'h0;
            if (s == 4) pin <= 1;
        end
        @(posedge clk) begin t0 <= 0; t1 <= 0; tlo <= 4'h0; pin <= 0; end
    endtask
    // Poll the done flag, never the active bit
    task wait_done(output logic [7:0] c);
        int n;
        for (n = 0; n < 200; n++) begin
            rd_reg(`ADDR_CONTROL, c);
            if (c[`CTL_DONE] === 1'b1) break;
        end
    endtask
    task run_conv(input int s, input logic lp, input logic lj,
                  input logic eb, input logic [9:0] v,
                  input logic [7:0] eh, input logic [7:0] el);
        logic [7:0] c;
        code = v;
        wr_reg(`ADDR_CONFIG, {5'h01, lj, 2'h0});
        // Enable and source first; start acts on the stored settings
        wr_reg(`ADDR_CONTROL, {1'b1, lp, 1'b0, 1'b0, eb, 3'(s)});
        if (s == 0) wr_reg(`ADDR_CONTROL, {1'b1, lp, 1'b0, 1'b1, eb, 3'(s)});
        else fire(s);
        // Pin edge passes the synchroniser and edge detector first
        if (s == 4) repeat (2) @(posedge clk);
        rd_reg(`ADDR_CONTROL, c);
        chk({7'h0, c[`CTL_ACTIVE]}, 8'h01);
        wait_done(c);
        chk({7'h0, c[`CTL_DONE]}, 8'h01);
        chk({7'h0, c[`CTL_ACTIVE]}, 8'h00);
        rd_reg(`ADDR_RES_HIGH, c);
        chk(c, eh);
        rd_reg(`ADDR_RES_LOW, c);
        chk(c, el);
    endtask
    // Start attempts that must not produce a conversion
    task no_start(input logic [7:0] ctl, input logic hi);
        logic [7:0] c;
        wr_reg(`ADDR_CONTROL, ctl);
        @(posedge clk) thi <= {3'h0, hi};
        @(posedge clk) thi <= 4'h0;
        repeat (60) @(posedge clk);
        rd_reg(`ADDR_CONTROL, c);
        chk({7'h0, c[`CTL_DONE]}, 8'h00);
    endtask

    task test_reset_values;
        logic [7:0] c;
        rd_reg(`ADDR_CONTROL, c);
        chk(c, `RST_CONTROL);
        rd_reg(`ADDR_CONFIG, c);
        chk(c, {`RST_DIVIDER, 3'h0});
        rd_reg(8'h07, c);
        chk(c, 8'h00);
    endtask
    task test_formats;
        int i0;
        run_conv(0, 0, 0, 0, 10'h3ff, 8'h03, 8'hff);
        run_conv(0, 0, 1, 0, 10'h3ff, 8'hff, 8'hc0);
        run_conv(0, 0, 0, 0, 10'h200, 8'h02, 8'h00);
        run_conv(0, 0, 1, 0, 10'h100, 8'h40, 8'h00);
        run_conv(0, 0, 1, 1, 10'h3ff, 8'h00, 8'hff);
        run_conv(0, 1, 0, 0, 10'h155, 8'h01, 8'h55);
        i0 = irqs;
        run_conv(0, 0, 0, 0, 10'h000, 8'h00, 8'h00);
        chk(8'(irqs - i0), 8'h01);
    endtask
    task test_sources;
        int s;
        for (s = 1; s < 8; s++)
            run_conv(s, 0, 0, 0, 10'h2a5, 8'h02, 8'ha5);
        run_conv(4, 1, 1, 0, 10'h0f0, 8'h3c, 8'h00);
    endtask
    task test_refused;
        no_start(8'h10, 0);
        no_start({5'h10, SRC_TIMER2}, 1);
    endtask
    task test_temp;
        wr_reg(`ADDR_INPUT_SEL, {2'h0, `TEMP_SENSOR_SEL});
        repeat (2) @(posedge clk);
        chk({7'h0, temp}, 8'h01);
        wr_reg(`ADDR_INPUT_SEL, 8'h00);
        repeat (2) @(posedge clk);
        chk({7'h0, temp}, 8'h00);
    endtask
    task test_track;
        wr_reg(`ADDR_CONTROL, 8'h80);
        repeat (3) @(posedge clk);
        #1 chk({6'h0, pwr, trk}, 8'h03);
        @(posedge clk) standby <= 1;
        repeat (3) @(posedge clk);
        #1 chk({7'h0, trk}, 8'h00);
        @(posedge clk) standby <= 0;
    endtask

    task test_done;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        test_done;
    end
    initial begin
        {reset, wr, rd, pin, standby, t0, t1} = 7'h40;
        {addr, wdata, tlo, thi, code} = 0;
        num_errors = 0;
        checks = 0;
        irqs = 0;
        repeat (16) @(posedge clk);
        reset <= 0;
        test_reset_values;
        test_formats;
        test_sources;
        test_refused;
        test_temp;
        test_track;
        test_done;
    end
endmodule
